// file: scm_channel_ctrl.sv
// Serial channel register bank: clock divider select, mode, bus control and clocking.
// Functional notes
// R1 - Reset loads clock select register with 88h, divider code 1000.
// R2 - Software writes clock select bits 6..4 as zero, bit 7 as one.
// R3 - Divider code picks fxx over 2^5..2^12 in I2C, 2^1..2^8 otherwise.
// R4 - fxx is the oscillator clock or its half per oscillator mode bit.
// R5 - Software stops transfers before rewriting the clock select register.
// R6 - Clock select takes byte writes only; mode register takes bit and byte.
// R7 - Reset clears mode register, leaving the channel stopped.
// R8 - Clock source: 0x external pin, 10 timer 2 output, 11 divider.
// R9 - Timer 2 output is divided by sixteen in I2C mode.
// R10 - Mode code picks 3-wire MSB/LSB or 2-wire on second or first data pin.
// R11 - Transmit-only 3-wire mode frees the serial input pin as a port.
// R12 - Wake-up 0 interrupts per transfer; 1 only on matched address after start.
// R13 - Read-only match flag shows slave address equals shift data; writes ignored.
// R14 - Match flag forced to zero while channel is disabled.
// R15 - Channel enable bit stops or enables all serial operation.
// R16 - Reset clears the bus control register.
// R17 - Software avoids prohibited divider and mode codes; results undefined.
`default_nettype none
module scm_channel_ctrl
  import scm_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // CPU register access.
  input wire scm_bus_req_s i_bus,
  output logic [7:0] o_bus_rdata,
  // Clock selection and transmit-only inputs.
  input wire logic i_osc_mode,
  input wire logic i_timer2_out,
  input wire logic i_sclk_pin,
  input wire logic i_i2c_sel,
  input wire logic i_tx_only,
  // Datapath status.
  input wire logic [7:0] i_slave_addr,
  input wire logic [7:0] i_shift_data,
  input wire logic i_xfer_done,
  input wire logic i_addr_rcvd,
  input wire logic [7:0] i_busctl_status,
  // Channel outputs.
  output logic o_serial_clk,
  output logic o_channel_en,
  output scm_mode_e o_mode,
  output scm_pin_cfg_s o_pin_cfg,
  output logic o_irq,
  output logic [7:0] o_busctl
);

  logic [7:0] clksel_r;
  logic [7:0] mode_r;
  logic [7:0] busctl_r;
  logic match_r;
  logic half_r;
  logic [15:0] div_cnt_r;
  logic [SCM_TMR_DIV_BITS-1:0] tmr_cnt_r;
  logic tmr_prev_r;
  logic pin_meta_r;
  logic pin_sync_r;
  logic fxx_tick;
  logic [3:0] div_idx;
  logic sclk_nxt;
  logic match_nxt;
  logic hit_clksel;
  logic hit_mode;
  logic hit_busctl;
  scm_mode_e mode_nxt;

  // Merge a single-bit write into a byte, or pass a whole byte through.
  function automatic logic [7:0] merge_wr(input logic [7:0] old, input scm_bus_req_s req);
    logic [7:0] mask;
    mask = 8'h01 << req.bit_pos;
    if (req.bit_op) begin
      merge_wr = (old & ~mask) | (req.wdata & mask);
    end else begin
      merge_wr = req.wdata;
    end
  endfunction

  assign hit_clksel = i_bus.wr && (i_bus.addr == SCM_ADDR_CLKSEL);
  assign hit_mode = i_bus.wr && (i_bus.addr == SCM_ADDR_MODE);
  assign hit_busctl = i_bus.wr && (i_bus.addr == SCM_ADDR_BUSCTL);

  // Clock select register; bit operations are dropped, the upper nibble is kept as written.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      clksel_r <= SCM_RST_CLKSEL; // see R1
    end else if (hit_clksel && !i_bus.bit_op) begin // see R6
      clksel_r <= i_bus.wdata; // see R2
    end
  end

  // Mode register; the match bit is never stored from a write.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_r <= SCM_RST_MODE; // see R7
    end else if (hit_mode) begin
      mode_r <= merge_wr(mode_r, i_bus) & ~(8'h01 << SCM_BIT_MATCH); // see R6, R13
    end
  end

  // Bus control register; detect bits track the datapath while enabled and clear while stopped; reads see the copy registered on the previous edge.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      busctl_r <= SCM_RST_BUSCTL; // see R16
    end else if (!mode_r[SCM_BIT_ENABLE]) begin
      busctl_r <= busctl_r & ~SCM_BUSCTL_RO_MASK;
    end else if (hit_busctl) begin
      busctl_r <= (merge_wr(busctl_r, i_bus) & ~SCM_BUSCTL_RO_MASK)
                  | (i_busctl_status & SCM_BUSCTL_RO_MASK);
    end else begin
      busctl_r <= (busctl_r & ~SCM_BUSCTL_RO_MASK) | (i_busctl_status & SCM_BUSCTL_RO_MASK);
    end
  end

  // Address comparator flag, held low while the channel is off.
  assign match_nxt = mode_r[SCM_BIT_ENABLE] && (i_slave_addr == i_shift_data); // see R13, R14
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      match_r <= 1'b0;
    end else begin
      match_r <= match_nxt;
    end
  end

  // Read data, registered one cycle after the address is presented.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_bus_rdata <= 8'h00;
    end else begin
      case (i_bus.addr)
        SCM_ADDR_CLKSEL: o_bus_rdata <= clksel_r;
        SCM_ADDR_MODE: o_bus_rdata <= mode_r | ({7'h00, match_r} << SCM_BIT_MATCH);
        SCM_ADDR_BUSCTL: o_bus_rdata <= busctl_r;
        default: o_bus_rdata <= 8'h00;
      endcase
    end
  end

  // The clock pin comes from outside, so it is synchronised before use.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= i_sclk_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  // fxx runs every core cycle, or every second one when the half rate is chosen.
  assign fxx_tick = i_osc_mode || half_r; // see R4
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !mode_r[SCM_BIT_ENABLE]) begin
      half_r <= 1'b0;
    end else begin
      half_r <= !half_r;
    end
  end

  // Power-of-two prescaler; held at zero while the channel is stopped to save power.
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !mode_r[SCM_BIT_ENABLE]) begin // see R15
      div_cnt_r <= 16'h0000;
    end else if (fxx_tick) begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  // Timer output divided by sixteen, counted on its rising edges.
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !mode_r[SCM_BIT_ENABLE]) begin
      tmr_prev_r <= 1'b0;
      tmr_cnt_r <= '0;
    end else begin
      tmr_prev_r <= i_timer2_out;
      if (i_timer2_out && !tmr_prev_r) begin
        tmr_cnt_r <= tmr_cnt_r + {{(SCM_TMR_DIV_BITS-1){1'b0}}, 1'b1}; // see R9
      end
    end
  end

  // Counter bit k is fxx divided by 2^(k+1); prohibited codes give an undefined rate.
  assign div_idx = clksel_r[3:0] - (i_i2c_sel ? SCM_IDX_OFS_I2C : SCM_IDX_OFS_WIRE); // see R3, R17

  // Serial clock source selection.
  always_comb begin
    if (!mode_r[SCM_BIT_ENABLE]) begin
      sclk_nxt = SCM_SCLK_IDLE; // see R15
    end else if (!mode_r[SCM_BIT_SRC1]) begin
      sclk_nxt = pin_sync_r; // see R8
    end else if (!mode_r[SCM_BIT_SRC1-1]) begin
      sclk_nxt = i_i2c_sel ? tmr_cnt_r[SCM_TMR_DIV_BITS-1] : i_timer2_out; // see R8, R9
    end else begin
      sclk_nxt = div_cnt_r[div_idx]; // see R3
    end
  end

  // Mode decode; bit 3 is a don't-care in 3-wire mode.
  always_comb begin
    if (!mode_r[SCM_BIT_MODE4]) begin
      mode_nxt = mode_r[SCM_BIT_MODE2] ? SCM_MODE_3W_LSB : SCM_MODE_3W_MSB; // see R10
    end else begin
      mode_nxt = mode_r[SCM_BIT_MODE2] ? SCM_MODE_2W_D0 : SCM_MODE_2W_D1; // see R10
    end
  end

  // Registered channel outputs.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_serial_clk <= SCM_SCLK_IDLE;
      o_channel_en <= 1'b0;
      o_mode <= SCM_MODE_3W_MSB;
      o_pin_cfg <= '0;
      o_busctl <= SCM_RST_BUSCTL;
    end else begin
      o_serial_clk <= sclk_nxt;
      o_channel_en <= mode_r[SCM_BIT_ENABLE]; // see R15
      o_mode <= mode_nxt;
      o_busctl <= busctl_r;
      o_pin_cfg.data0_od <= (mode_nxt == SCM_MODE_2W_D0); // see R10
      o_pin_cfg.data1_od <= (mode_nxt == SCM_MODE_2W_D1);
      o_pin_cfg.clk_od <= mode_r[SCM_BIT_MODE4];
      o_pin_cfg.data1_port <= (mode_nxt == SCM_MODE_2W_D0);
      o_pin_cfg.data0_port <= (mode_nxt == SCM_MODE_2W_D1)
                              || (!mode_r[SCM_BIT_MODE4] && i_tx_only); // see R11
      o_pin_cfg.lsb_first <= (mode_nxt == SCM_MODE_3W_LSB);
    end
  end

  // Interrupt pulse; in wake-up mode only a matched address after a start counts, and only with I2C selected.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else if (!mode_r[SCM_BIT_ENABLE]) begin
      o_irq <= 1'b0;
    end else if (mode_r[SCM_BIT_WAKEUP]) begin
      o_irq <= i_i2c_sel && i_addr_rcvd && busctl_r[3] && match_nxt; // see R12
    end else begin
      o_irq <= i_xfer_done; // see R12
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_byte_clksel;
    hit_clksel && !i_bus.bit_op;
  endsequence

  reset_clksel_a: assert property ($fell(i_rst) |-> $past(clksel_r) == 8'h88) // see R1
    else $error("Clock select not 88h after reset.");
  bitwr_clksel_a: assert property (hit_clksel && i_bus.bit_op |=> $stable(clksel_r)) // see R6
    else $error("Bit write changed clock select.");
  bytewr_clksel_a: assert property (s_byte_clksel |=> clksel_r == $past(i_bus.wdata)) // see R6
    else $error("Byte write lost in clock select.");
  reset_mode_a: assert property ($fell(i_rst) |-> $past(mode_r) == 8'h00) // see R7
    else $error("Mode register not cleared by reset.");
  match_off_a: assert property (!mode_r[7] |=> !match_r) // see R14
    else $error("Match flag set while channel disabled.");
  match_eq_a: assert property (mode_r[7] && (i_slave_addr == i_shift_data) |=> match_r) // see R13
    else $error("Match flag missed equal address.");
  irq_xfer_a: assert property (mode_r[7] && !mode_r[5] && i_xfer_done |=> o_irq) // see R12
    else $error("Transfer did not raise interrupt.");
  irq_wake_a: assert property (mode_r[5] && !i_addr_rcvd |=> !o_irq) // see R12
    else $error("Wake-up interrupt without address.");
  stop_clk_a: assert property ( // see R15
    !mode_r[7] [*2] |=> o_serial_clk == 1'b1 && !o_channel_en)
    else $error("Serial clock active while stopped.");
  reset_busctl_a: assert property ($fell(i_rst) |-> $past(busctl_r) == 8'h00) // see R16
    else $error("Bus control not cleared by reset.");
  pin_2w_a: assert property ( // see R10
    mode_r[4:2] == 3'b111 |=> o_pin_cfg.data0_od && o_pin_cfg.data1_port)
    else $error("Pin roles wrong for first-pin 2-wire.");

endmodule
`default_nettype wire

// file: scm_pkg.sv
// Shared constants and types for the serial channel mode and clock control block.
`default_nettype none
package scm_pkg;
  // Register byte addresses in CPU memory space.
  localparam logic [15:0] SCM_ADDR_CLKSEL = 16'hff43;
  localparam logic [15:0] SCM_ADDR_MODE = 16'hff60;
  localparam logic [15:0] SCM_ADDR_BUSCTL = 16'hff61;
  // Values after reset.
  localparam logic [7:0] SCM_RST_CLKSEL = 8'h88;
  localparam logic [7:0] SCM_RST_MODE = 8'h00;
  localparam logic [7:0] SCM_RST_BUSCTL = 8'h00;
  // Field positions in the mode register.
  localparam int SCM_BIT_ENABLE = 7;
  localparam int SCM_BIT_MATCH = 6;
  localparam int SCM_BIT_WAKEUP = 5;
  localparam int SCM_BIT_MODE4 = 4;
  localparam int SCM_BIT_MODE3 = 3;
  localparam int SCM_BIT_MODE2 = 2;
  localparam int SCM_BIT_SRC1 = 1;
  // Read-only bits of the bus control register (stop, start, acknowledge detect).
  localparam logic [7:0] SCM_BUSCTL_RO_MASK = 8'h4c;
  // Offsets that turn a divider code into a counter bit index (code 0110 is the first).
  localparam logic [3:0] SCM_IDX_OFS_I2C = 4'h2;
  localparam logic [3:0] SCM_IDX_OFS_WIRE = 4'h6;
  // Timer output division in I2C mode is 16, the top bit of a 4-bit counter.
  localparam int SCM_TMR_DIV_BITS = 4;
  // Serial clock idles high while the channel is stopped.
  localparam logic SCM_SCLK_IDLE = 1'b1;

  // Operating mode, Gray coded.
  typedef enum logic [1:0] {
    SCM_MODE_3W_MSB = 2'b00,
    SCM_MODE_3W_LSB = 2'b01,
    SCM_MODE_2W_D1 = 2'b11,
    SCM_MODE_2W_D0 = 2'b10
  } scm_mode_e;

  // Pin roles implied by the selected mode.
  typedef struct packed {
    logic data0_od;    // First data pin is open-drain serial data.
    logic data0_port;  // First data pin released as a general port.
    logic data1_od;    // Second data pin is open-drain serial data.
    logic data1_port;  // Second data pin released as a general port.
    logic clk_od;      // Clock pin is open-drain.
    logic lsb_first;   // Shift order is LSB first.
  } scm_pin_cfg_s;

  // CPU register access.
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic bit_op;
    logic [2:0] bit_pos;
    logic [7:0] wdata;
  } scm_bus_req_s;
endpackage
`default_nettype wire

// file: scm_ext_peer.sv
// Behavioural far-side peer that supplies an external serial clock.
`default_nettype none
module scm_ext_peer #(
  parameter int HALF = 5
) (
  // Bench clock and channel enable.
  input wire logic i_clk,
  input wire logic i_en,
  // Serial clock driven onto the clock pin.
  output logic o_sclk
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial o_sclk = 1'b1;
  // The clock stands high while the channel is disabled, as a pulled-up idle line does.
  always @(posedge i_clk) begin
    cnt <= (!i_en || cnt == HALF - 1) ? 0 : cnt + 1;
    o_sclk <= !i_en ? 1'b1 : (cnt == HALF - 1 ? ~o_sclk : o_sclk);
  end
endmodule
`default_nettype wire

// file: serial_channel_mode_clock_control_test.sv
// Self-checking bench for the serial channel mode and clock control block.
`default_nettype none
module serial_channel_mode_clock_control_test
  import scm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, osc, tmr, i2c, txo, xfer, rcvd, tgl, sclk_pin, sclk, en, irq;
  logic [7:0] sla, shd, bst, rdata, bctl, m;
  scm_bus_req_s bus;
  scm_mode_e mode;
  scm_pin_cfg_s pin;
  int n_mismatch, n_tests, p, c;
  logic bi, bo;
  logic [2:0] mc [6] = '{3'h0, 3'h1, 3'h6, 3'h7, 3'h2, 3'h0};
  logic [7:0] em [6] = '{8'h00, 8'h41, 8'hda, 8'ha6, 8'h00, 8'h10};

  scm_channel_ctrl u_scm_channel_ctrl (.i_core_clk(clk), .i_rst(rst), .i_bus(bus),
    .o_bus_rdata(rdata), .i_osc_mode(osc), .i_timer2_out(tmr), .i_sclk_pin(sclk_pin),
    .i_i2c_sel(i2c), .i_tx_only(txo), .i_slave_addr(sla), .i_shift_data(shd),
    .i_xfer_done(xfer), .i_addr_rcvd(rcvd), .i_busctl_status(bst), .o_serial_clk(sclk),
    .o_channel_en(en), .o_mode(mode), .o_pin_cfg(pin), .o_irq(irq), .o_busctl(bctl));
  scm_ext_peer u_scm_ext_peer (.i_clk(clk), .i_en(en), .o_sclk(sclk_pin));

  // Clock generator.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Timer output toggles every cycle when asked, so it rises every two cycles.
  always @(posedge clk) tmr <= tgl ? ~tmr : 1'b0;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Write strobe holds for exactly one taken edge.
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 1'b0,
                    input logic [2:0] q = 3'h0);
    @(posedge clk);
    bus <= '{a, 1'b1, b, q, d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    bus.addr <= a;
    @(posedge clk);
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  // Period in core cycles between the second and third rising edges seen.
  task automatic meas(output int pr);
    int n;
    int e[$];
    logic pv;
    n = 0;
    #1 pv = sclk;
    while (e.size() < 3 && n < 20000) begin
      @(posedge clk);
      #1 n++;
      if (sclk === 1'b1 && pv === 1'b0) e.push_back(n);
      pv = sclk;
    end
    pr = (e.size() == 3) ? e[2] - e[1] : -1;
  endtask
  // One event pulse, then the interrupt is expected to equal e for one cycle and be low the next.
  task automatic pulse(input logic x, input logic a, input logic e);
    @(posedge clk);
    xfer <= x;
    rcvd <= a;
    @(posedge clk);
    xfer <= 1'b0;
    rcvd <= 1'b0;
    #1 chk({15'h0, irq}, {15'h0, e});
    @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0000);
  endtask
  // Divider rate: fxx is fx or fx/2, I2C codes start four octaves lower.
  function automatic int exp_per(input int cd, input logic i, input logic o);
    return (o ? 1 : 2) << (cd - (i ? 1 : 5));
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog sized well above the longest divider measurements.
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end

  // Main sequence.
  initial begin
    {osc, i2c, txo, xfer, rcvd, tgl} = '0;
    rst = 1'b1;
    bus = '0;
    {sla, shd, bst} = '0;
    void'($urandom(63028));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(16'hff43, 8'h88);
    rd(16'hff60, 8'h00);
    rd(16'hff61, 8'h00);
    chk({8'h00, bctl}, 16'h0000);
    rd(16'hff50, 8'h00);
    wr(16'hff43, 8'h01, 1'b1, 3'h0);
    rd(16'hff43, 8'h88);
    m = 8'($urandom);
    sla <= m;
    shd <= m;
    wr(16'hff60, 8'hff, 1'b1, 3'h7);
    rd(16'hff60, 8'hc0);
    chk({15'h0, en}, 16'h0001);
    wr(16'hff60, 8'h40);
    rd(16'hff60, 8'h00);
    wr(16'hff60, 8'hc0);
    shd <= ~m;
    rd(16'hff60, 8'h80);
    // Every operating mode, plus transmit-only use of the three-wire mode.
    for (int k = 0; k < 6; k++) begin
      txo <= (k == 5);
      wr(16'hff60, {3'b100, mc[k], 2'b11});
      repeat (3) @(posedge clk);
      #1 chk({8'h00, mode, pin}, {8'h00, em[k]});
    end
    txo <= 1'b0;
    // Random legal divider codes; the channel is stopped around each rewrite.
    for (int k = 0; k < 6; k++) begin
      bi = k[0];
      bo = 1'($urandom);
      c = bi ? 7 + $urandom % 3 : 7 + $urandom % 7;
      wr(16'hff60, 8'h00);
      i2c <= bi;
      osc <= bo;
      wr(16'hff43, {4'h8, 4'(c)});
      wr(16'hff60, bi ? 8'h9b : 8'h83);
      meas(p);
      chk(16'(p), 16'(exp_per(c, bi, bo)));
    end
    i2c <= 1'b0;
    wr(16'hff60, 8'h80);
    meas(p);
    chk(16'(p), 16'h000a);
    tgl <= 1'b1;
    i2c <= 1'b1;
    wr(16'hff60, 8'h9a);
    meas(p);
    chk(16'(p), 16'h0020);
    tgl <= 1'b0;
    // Wake-up on matched address after start, then per-transfer interrupts.
    wr(16'hff60, 8'hbb);
    bst <= 8'h08;
    shd <= m;
    // Writable bus control bits are stored, the detect bits follow the datapath.
    wr(16'hff61, 8'hff);
    rd(16'hff61, 8'hbb);
    chk({8'h00, bctl}, 16'h00bb);
    pulse(1'b0, 1'b1, 1'b1);
    pulse(1'b1, 1'b0, 1'b0);
    shd <= ~m;
    pulse(1'b0, 1'b1, 1'b0);
    i2c <= 1'b0;
    wr(16'hff60, 8'h83);
    pulse(1'b1, 1'b0, 1'b1);
    wr(16'hff60, 8'h03);
    pulse(1'b1, 1'b0, 1'b0);
    chk({8'h00, bctl}, 16'h00b3);
    // A second reset in mid-run, held two edges so the registers settle first.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(16'hff43, 8'h88);
    rd(16'hff60, 8'h00);
    rd(16'hff61, 8'h00);
    chk({8'h00, bctl}, 16'h0000);
    wrap_up;
  end
endmodule
`default_nettype wire
